//--- dv/stream_side_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Stream side: rates and selectors
// ----
module stream_side_model
  import stream_align_pkg::*;
(
  // From bench
  input wire logic [2:0] rateSet,
  input wire logic [4:0] selSet,
  // To device
  output logic [2:0] streamRate [STREAM_COUNT],
  output logic [4:0] inStreamSel,
  output logic [4:0] outStreamSel
);
  // All streams share one rate, so any stream shows it
  always_comb begin
    for (int i = 0; i < STREAM_COUNT; i++) begin
      streamRate[i] = rateSet;
    end
    inStreamSel = selSet;
    outStreamSel = selSet;
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import stream_align_pkg::*;
  // ----
  // Signals
  // ----
  logic ref_clk = 0;
  logic resetn = 0;
  logic regWrite = 0;
  logic regRead = 0;
  logic regRdReady = 0;
  logic fastMode = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regReady, regRdValid, inStreamActive;
  logic [15:0] regRdata;
  logic [2:0] rateSet = 3'h0;
  logic [4:0] selSet = 5'h00;
  logic [2:0] streamRate [STREAM_COUNT];
  logic [4:0] inStreamSel, outStreamSel;
  logic [8:0] inChanDelay;
  logic [6:0] inQuarterDelay;
  logic [2:0] outAdvanceCycles;
  int errCount = 0;
  int testsRun = 0;
  int cycles = 0;
  stream_side_model i_side (.rateSet(rateSet), .selSet(selSet),
    .streamRate(streamRate), .inStreamSel(inStreamSel), .outStreamSel(outStreamSel));
  stream_delay_advance_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regReady(regReady), .regRdValid(regRdValid), .regRdReady(regRdReady),
    .regRdata(regRdata), .fastMode(fastMode), .streamRate(streamRate),
    .inStreamSel(inStreamSel), .outStreamSel(outStreamSel),
    .inChanDelay(inChanDelay), .inQuarterDelay(inQuarterDelay),
    .inStreamActive(inStreamActive), .outAdvanceCycles(outAdvanceCycles));
  // ----
  // Clock and hang guard
  // ----
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    // Run needs well under a thousand cycles
    if (cycles == 5000) begin
      errCount++;
      stop_test();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask
  // Hold the read until the edge that takes it
  task automatic rdReq(input logic [7:0] a);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    // Ready is settled at the falling edge; the next rising edge takes it
    while (regReady !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    regRead = 1'b0;
  endtask
  // Called just after a falling edge
  task automatic drain(input logic [15:0] exp);
    check(16'(regRdValid), 16'h0001);
    check(regRdata, exp);
    regRdReady = 1'b1;
    @(negedge ref_clk);
    regRdReady = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rdReq(a);
    drain(exp);
  endtask
  // Outputs register one edge after a change
  task automatic align(input logic [8:0] c, input logic [6:0] q, input logic [2:0] v, input logic act);
    repeat (2) @(negedge ref_clk);
    check(16'(inChanDelay), 16'(c));
    check(16'(inQuarterDelay), 16'(q));
    check(16'(outAdvanceCycles), 16'(v));
    check(16'(inStreamActive), 16'(act));
  endtask
  // ----
  // Scenarios
  // ----
  logic [7:0] edgeAddr [6] = '{8'h43, 8'h62, 8'h63, 8'h82, 8'h83, 8'ha2};
  logic [15:0] edgeMask [6] = '{16'h01ff, 16'h01ff, 16'h001f, 16'h001f, 16'h0003, 16'h0003};
  task automatic tReset;
    foreach (edgeAddr[i]) rd(edgeAddr[i], 16'h0000);
  endtask
  // Reserved bits drop; edges of map and the addresses just outside it
  task automatic tFields;
    foreach (edgeAddr[i]) begin
      wr(edgeAddr[i], 16'hffff);
      rd(edgeAddr[i], edgeMask[i]);
    end
    wr(8'h42, 16'hffff);
    rd(8'h42, 16'h0000);
    wr(8'ha3, 16'hffff);
    rd(8'ha3, 16'h0000);
  endtask
  // Two unread words fill the buffer
  task automatic tFull;
    wr(8'h45, 16'h0005);
    wr(8'h65, 16'h0006);
    rdReq(8'h45);
    rdReq(8'h65);
    @(negedge ref_clk);
    regAddr = 8'h85;
    regRead = 1'b1;
    @(posedge ref_clk);
    check(16'(regReady), 16'h0000);
    @(negedge ref_clk);
    regRead = 1'b0;
    drain(16'h0005);
    drain(16'h0006);
    check(16'(regRdValid), 16'h0000);
  endtask
  // Clamp per rate, bit delay at every rate
  task automatic tRates;
    selSet = 5'h01;
    wr(8'h44, 16'h01ff);
    wr(8'h64, 16'h0013);
    wr(8'h84, 16'h0000);
    for (int r = 0; r < 5; r++) begin
      rateSet = 3'(r);
      align(9'((32 << r) - 1), 7'h13, 3'h0, 1'b1);
    end
    wr(8'h44, 16'h0000);
    align(9'h000, 7'h13, 3'h0, 1'b1);
  endtask
  task automatic tAdvance;
    for (int c = 0; c < 4; c++) begin
      wr(8'h84, 16'(c));
      align(9'h000, 7'h13, 3'(2 * c), 1'b1);
    end
  endtask
  // A second reset clears fields and outputs
  task automatic tMidReset;
    wr(8'h44, 16'h0155);
    align(9'h155, 7'h13, 3'h6, 1'b1);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    check(16'(regRdValid), 16'h0000);
    check(16'(inStreamActive), 16'h0000);
    align(9'h000, 7'h00, 3'h0, 1'b1);
    rd(8'h44, 16'h0000);
    rd(8'h64, 16'h0000);
    rd(8'h84, 16'h0000);
  endtask
  // Upper half idle in fast mode; slowest rate shows the lifted clamp
  task automatic tFast;
    fastMode = 1'b1;
    rateSet = 3'h0;
    selSet = 5'h0f;
    wr(8'h52, 16'h01ff);
    wr(8'h72, 16'h001f);
    align(9'h1ff, 7'h1f, 3'h0, 1'b1);
    selSet = 5'h10;
    align(9'h000, 7'h00, 3'h0, 1'b0);
  endtask
  // ----
  // Sequence and verdict
  // ----
  task automatic stop_test;
    $display("Checks %0d errors %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    tReset();
    tFields();
    tFull();
    tRates();
    tAdvance();
    tMidReset();
    tFast();
    stop_test();
  end
endmodule
`default_nettype wire

//--- inc/reg_req_if.sv
`timescale 1ns/1ns
`default_nettype none
// Request and answer between the register bank and the buffer
interface reg_req_if;
  logic valid;
  logic ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- inc/stream_align_pkg.sv
// How it works
// - 32 channel delay registers at 0x43-0x62
// - Channel delay nine bits, upper bits reserved
// - Largest channel delay depends on stream rate
// - Plain binary delay count, zero default
// - 32 bit delay registers at 0x63-0x82
// - Bit delay five bits, quarter-bit steps
// - Bit delay sets bit 0 capture point
// - Quarter-bit delay applies at every rate
// - 32Mb/s mode uses only streams 0-15; here only the receiver idles 16-31, outAdvanceCycles still serves them
// - 32 advance registers at 0x83-0xa2
// - Advance field two bits, internal clock cycles
// - Codes 00,01,10,11 give 0,2,4,6 cycles
package stream_align_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CHAN_DELAY_BASE = 8'h43;
  localparam logic [7:0] BIT_DELAY_BASE = 8'h63;
  localparam logic [7:0] OUT_ADVANCE_BASE = 8'h83;
  localparam int STREAM_COUNT = 32;
  localparam int STREAM_COUNT_FAST = 16;
  // ----------------------------------------
  // Field widths and resets
  // ----------------------------------------
  localparam int CHAN_DELAY_WIDTH = 9;
  localparam int BIT_DELAY_WIDTH = 5;
  localparam int OUT_ADVANCE_WIDTH = 2;
  localparam logic [8:0] CHAN_DELAY_RESET = 9'h000;
  localparam logic [4:0] BIT_DELAY_RESET = 5'h00;
  localparam logic [1:0] OUT_ADVANCE_RESET = 2'h0;
  // ----------------------------------------
  // Stream rate codes and per-rate limits
  // ----------------------------------------
  typedef enum logic [2:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M, RATE_32M} rate_e;
  localparam logic [8:0] MAX_DELAY_2M = 9'h01f;
  localparam logic [8:0] MAX_DELAY_4M = 9'h03f;
  localparam logic [8:0] MAX_DELAY_8M = 9'h07f;
  localparam logic [8:0] MAX_DELAY_16M = 9'h0ff;
  localparam logic [8:0] MAX_DELAY_32M = 9'h1ff;
  // Advance step in internal clock cycles per code unit
  localparam logic [2:0] ADVANCE_STEP = 3'h2;
endpackage

//--- rtl/stream_delay_advance_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Per-stream delay and advance register bank with alignment outputs
module stream_delay_advance_ctrl
  import stream_align_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Processor port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWdata,
  output logic regReady,
  output logic regRdValid,
  input wire logic regRdReady,
  output logic [15:0] regRdata,
  // Backplane mode and per-stream rates
  input wire logic fastMode,
  input wire logic [2:0] streamRate [STREAM_COUNT],
  // Stream selectors for alignment lookup
  input wire logic [4:0] inStreamSel,
  input wire logic [4:0] outStreamSel,
  // Alignment settings for the receiver and transmitter
  output logic [8:0] inChanDelay,
  output logic [6:0] inQuarterDelay,
  output logic inStreamActive,
  output logic [2:0] outAdvanceCycles
);
  // ----------------------------------------
  // Register arrays
  // ----------------------------------------
  logic [8:0] chanDelay [STREAM_COUNT]; // Channel delay fields
  logic [4:0] bitDelay [STREAM_COUNT]; // Quarter-bit delay fields
  logic [1:0] outAdvance [STREAM_COUNT]; // Output advance codes

  // Decode whether an address falls in the array starting at base
  function automatic logic in_array(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    in_array = (addr >= base) && (diff < 8'(STREAM_COUNT));
  endfunction

  // Largest legal channel delay for a rate
  function automatic logic [8:0] max_delay(input logic [2:0] rate);
    case (rate)
      RATE_2M: max_delay = MAX_DELAY_2M;
      RATE_4M: max_delay = MAX_DELAY_4M;
      RATE_8M: max_delay = MAX_DELAY_8M;
      RATE_16M: max_delay = MAX_DELAY_16M;
      // Unused codes fall to the widest limit rather than to zero
      default: max_delay = MAX_DELAY_32M;
    endcase
  endfunction

  wire [4:0] chanIdx = 5'(regAddr - CHAN_DELAY_BASE);
  wire [4:0] bitIdx = 5'(regAddr - BIT_DELAY_BASE);
  wire [4:0] advIdx = 5'(regAddr - OUT_ADVANCE_BASE);
  wire hitChan = in_array(regAddr, CHAN_DELAY_BASE);
  wire hitBit = in_array(regAddr, BIT_DELAY_BASE);
  wire hitAdv = in_array(regAddr, OUT_ADVANCE_BASE);

  // ----------------------------------------
  // Read path buffer
  // ----------------------------------------
  reg_req_if rdReq ();
  logic [15:0] next_rdata;

  // Reads stall while the buffer is full; writes never stall
  // A write and a read in one cycle: the write goes, the read is not taken though regReady is high
  assign regReady = regWrite || rdReq.ready;
  assign rdReq.valid = regRead && !regWrite;
  assign rdReq.data = next_rdata;

  two_entry_buffer u_rd_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inSide(rdReq),
    .outValid(regRdValid),
    .outReady(regRdReady),
    .outData(regRdata)
  );

  // Read mux: reserved bits and unmapped addresses give zero
  always_comb begin
    next_rdata = 16'h0000;
    if (hitChan) begin
      next_rdata = {7'h00, chanDelay[chanIdx]};
    end else if (hitBit) begin
      next_rdata = {11'h000, bitDelay[bitIdx]};
    end else if (hitAdv) begin
      next_rdata = {14'h0000, outAdvance[advIdx]};
    end
  end

  // ----------------------------------------
  // Register writes, one generate slice per stream
  // ----------------------------------------
  // Reserved bits of each word are simply never stored
  genvar s;
  generate
    for (s = 0; s < STREAM_COUNT; s++) begin : g_stream
      // Channel delay, plain binary count, zero default
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          chanDelay[s] <= CHAN_DELAY_RESET;
        end else if (regWrite && hitChan && chanIdx == 5'(s)) begin
          chanDelay[s] <= regWdata[8:0];
        end
      end
      // Quarter-bit delay
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          bitDelay[s] <= BIT_DELAY_RESET;
        end else if (regWrite && hitBit && bitIdx == 5'(s)) begin
          bitDelay[s] <= regWdata[4:0];
        end
      end
      // Output advance code
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          outAdvance[s] <= OUT_ADVANCE_RESET;
        end else if (regWrite && hitAdv && advIdx == 5'(s)) begin
          outAdvance[s] <= regWdata[1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Alignment outputs
  // ----------------------------------------
  // The stored field is kept whole; clamping only shapes the receiver's view,
  // so software reads back exactly what it wrote
  // Selectors are levels; a change shows one edge later
  logic [2:0] selRate;
  logic [8:0] selLimit;
  logic selActive;
  always_comb begin
    // Fast mode forces every stream to the top rate
    selRate = fastMode ? 3'(RATE_32M) : streamRate[inStreamSel];
    selLimit = max_delay(selRate);
    // Upper half idle in 32Mb/s mode
    selActive = !fastMode || (inStreamSel < 5'(STREAM_COUNT_FAST));
  end

  // Registered receiver settings
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      inChanDelay <= CHAN_DELAY_RESET;
      inQuarterDelay <= 7'h00;
      inStreamActive <= 1'b0;
    end else begin
      inStreamActive <= selActive;
      if (!selActive) begin
        inChanDelay <= CHAN_DELAY_RESET;
        inQuarterDelay <= 7'h00;
      end else begin
        inChanDelay <= (chanDelay[inStreamSel] > selLimit) ? selLimit : chanDelay[inStreamSel];
        // Bit 0 capture point in quarter-bit units, same at every rate
        inQuarterDelay <= {2'h0, bitDelay[inStreamSel]};
      end
    end
  end

  // Registered transmitter advance in internal clock cycles
  // Code times step; three bits hold the largest count, six
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      outAdvanceCycles <= 3'h0;
    end else begin
      outAdvanceCycles <= 3'(outAdvance[outStreamSel] * ADVANCE_STEP);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Write checks look one edge later, once the field has settled
  chk_adv_map: assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 outAdvanceCycles == 3'($past(outAdvance[outStreamSel]) * 2))
    else $error("advance code maps to wrong cycle count");
  chk_fast_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fastMode && inStreamSel >= 5'h10) |=> (!inStreamActive && inChanDelay == 9'h000))
    else $error("upper stream active in fast mode");
  chk_delay_limit: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!fastMode && streamRate[inStreamSel] == 3'(RATE_2M)) |=> inChanDelay <= 9'h01f)
    else $error("channel delay beyond rate limit");
  chk_chan_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWrite && hitChan) |=> chanDelay[$past(chanIdx)] == $past(regWdata[8:0]))
    else $error("channel delay write lost");
  chk_bit_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWrite && hitBit) |=> bitDelay[$past(bitIdx)] == $past(regWdata[4:0]))
    else $error("bit delay write lost");
  chk_quarter_pass: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!fastMode) |=> inQuarterDelay == {2'h0, $past(bitDelay[inStreamSel])})
    else $error("quarter delay not passed");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    hitAdv |-> next_rdata[15:2] == 14'h0000)
    else $error("reserved bits not zero");
  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regAddr < 8'h43 || regAddr > 8'ha2) |-> next_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // Advance writes land like the other two arrays
  chk_adv_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWrite && hitAdv) |=> outAdvance[$past(advIdx)] == $past(regWdata[1:0]))
    else $error("advance write lost");
  // No disable here: the reset itself is what is watched
  chk_reset_clear: assert property (@(posedge ref_clk)
    !resetn |=> (inChanDelay == 9'h000 && inQuarterDelay == 7'h00 &&
      outAdvanceCycles == 3'h0 && !inStreamActive))
    else $error("outputs not cleared by reset");
  // Lower half stays in use in fast mode
  chk_fast_lower: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fastMode && inStreamSel < 5'h10) |=> inStreamActive)
    else $error("lower stream idle in fast mode");
  // Fast mode lifts the clamp to the widest channel delay
  chk_fast_limit: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fastMode && inStreamSel < 5'h10) |=> inChanDelay == $past(chanDelay[inStreamSel]))
    else $error("fast mode clamped the channel delay");
endmodule
`default_nettype wire

//--- rtl/two_entry_buffer.sv
`timescale 1ns/1ns
`default_nettype none
// Two-entry skid buffer on the read data path
module two_entry_buffer
  import stream_align_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Filling side
  reg_req_if.dst inSide,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [15:0] outData
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] slot [2]; // Two words, oldest at rdPtr
  logic rdPtr; // Read pointer
  logic wrPtr; // Write pointer
  logic [1:0] fill; // Entries held

  wire push = inSide.valid && inSide.ready;
  wire pop = outValid && outReady;

  // Full stops the source, so a stalled reader loses nothing
  assign inSide.ready = (fill != 2'h2);
  assign outValid = (fill != 2'h0);
  assign outData = slot[rdPtr];

  // Word storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      slot[wrPtr] <= inSide.data;
    end
  end

  // Pointers and count
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdPtr <= 1'b0;
      wrPtr <= 1'b0;
      fill <= 2'h0;
    end else begin
      if (push) begin
        wrPtr <= ~wrPtr;
      end
      if (pop) begin
        rdPtr <= ~rdPtr;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  chk_no_overflow: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fill == 2'h2 && !pop) |=> fill == 2'h2)
    else $error("buffer dropped or lost a word");
endmodule
`default_nettype wire
